//--- rtl/psm_top.sv
// Feedback prescaler and status pin multiplexer with their control registers.
// Assumes all source signals and the swallow counter run on MCLK.
`timescale 1ns/1ps
`default_nettype none
module psm_top
  import psm_pkg::*;
#(
  parameter int ADDR_W = 10 // Control port address width
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  input wire logic SWALLOW_ZERO,
  input wire logic MOD_HI,
  input wire psm_src_t SRC,
  output logic PRESC_OUT,
  output logic B_BYPASS,
  output logic STATUS_PIN
);
  // Width check at elaboration: 0x01D needs five bits, the decode compares ten
  if (ADDR_W < 5 || ADDR_W > 10) begin : g_bad_addr_w
    $error("ADDR_W must be 5 to 10");
  end

  logic [7:0] presc_r, presc_nxt; // Prescaler control
  logic [7:0] stat_r, stat_nxt; // Status pin select
  logic [7:0] lock_r, lock_nxt; // Lock register
  logic [7:0] rdata_r, rdata_nxt; // Read data
  logic [5:0] cnt_r, cnt_nxt; // Prescaler down counter
  logic pout_r, pout_nxt; // Prescaler output
  logic byp_r, byp_nxt; // Effective bypass
  logic pin_r, pin_nxt; // Status pin
  logic [9:0] addr_full; // Address widened
  logic [2:0] pcode; // Prescaler code
  logic [5:0] sel; // Selector code
  logic fixed_mode; // Fixed divide active
  logic [5:0] ratio; // Current division ratio

  assign addr_full = 10'(ADDR);
  assign pcode = presc_r[PSM_PRESC_LSB +: 3];
  assign sel = stat_r[PSM_SEL_LSB +: 6];

  // Division ratio for a code, swallow state and modulus request
  function automatic logic [5:0] psm_ratio(input logic [2:0] c, input logic az, input logic hi);
    logic inc;
    inc = hi & ~az;
    unique case (c)
      PSM_P_FD1: psm_ratio = 6'h01;
      PSM_P_FD2: psm_ratio = 6'h02;
      PSM_P_FD3: psm_ratio = 6'h03;
      PSM_P_DM23: psm_ratio = inc ? 6'h03 : 6'h02;
      PSM_P_DM45: psm_ratio = inc ? 6'h05 : 6'h04;
      PSM_P_DM8: psm_ratio = az ? 6'h08 : (hi ? 6'h05 : 6'h04);
      PSM_P_DM16: psm_ratio = inc ? 6'h11 : 6'h10;
      PSM_P_DM32: psm_ratio = inc ? 6'h21 : 6'h20;
    endcase
  endfunction : psm_ratio

  // Pin encoding used by the status pin selector
  function automatic logic psm_mux(input logic [5:0] s, input psm_src_t x, input logic presc);
    unique case (s)
      PSM_S_GND: psm_mux = 1'b0;
      PSM_S_NDIV: psm_mux = x.n_div_dly;
      PSM_S_RDIV: psm_mux = x.r_div_dly;
      PSM_S_SWAL: psm_mux = x.swallow;
      PSM_S_PRESC: psm_mux = presc;
      PSM_S_UP: psm_mux = x.pfd_up;
      PSM_S_DN: psm_mux = x.pfd_dn;
      PSM_S_GND2: psm_mux = 1'b0;
      PSM_S_FIRST_REFERENCE_INPUT: psm_mux = x.first_reference_input;
      PSM_S_SECOND_REFERENCE_INPUT: psm_mux = x.diff_mode ? 1'b0 : x.second_reference_input;
      PSM_S_RSEL: psm_mux = (x.ref_sel2 & ~x.diff_mode) ? x.second_reference_input : x.first_reference_input;
      PSM_S_RUNS: psm_mux = x.diff_mode ? 1'b0 : (x.ref_sel2 ? x.first_reference_input : x.second_reference_input);
      default: psm_mux = 1'b0;
    endcase
  endfunction : psm_mux

  // Register writes and reads
  always_comb begin
    presc_nxt = presc_r;
    stat_nxt = stat_r;
    lock_nxt = lock_r;
    rdata_nxt = rdata_r;
    if (WR_EN) begin
      // Write decode
      if (addr_full == PSM_OFF_PRESC) begin
        presc_nxt = WDATA;
      end else if (addr_full == PSM_OFF_STAT && !lock_r[PSM_LOCK_BIT]) begin
        stat_nxt = WDATA;
      end else if (addr_full == PSM_OFF_LOCK) begin
        lock_nxt = WDATA;
      end
    end
    if (RD_EN) begin
      // Read decode, unmapped reads zero
      unique case (addr_full)
        PSM_OFF_PRESC: rdata_nxt = presc_r;
        PSM_OFF_STAT: rdata_nxt = stat_r;
        PSM_OFF_LOCK: rdata_nxt = lock_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      presc_r <= PSM_RST_PRESC;
      stat_r <= PSM_RST_STAT;
      lock_r <= PSM_RST_LOCK;
      rdata_r <= 8'h00;
    end else begin
      presc_r <= presc_nxt;
      stat_r <= stat_nxt;
      lock_r <= lock_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Prescaler divider and bypass
  always_comb begin
    fixed_mode = (pcode == PSM_P_FD1) || (pcode == PSM_P_FD2) || (pcode == PSM_P_FD3);
    ratio = psm_ratio(pcode, SWALLOW_ZERO, MOD_HI);
    if (cnt_r == 6'h00) begin
      // Terminal count: reload and pulse
      cnt_nxt = ratio - 6'h01;
      pout_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r - 6'h01;
      pout_nxt = 1'b0;
    end
    byp_nxt = presc_r[PSM_BYP_BIT] & fixed_mode;
    pin_nxt = psm_mux(sel, SRC, pout_r);
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      cnt_r <= 6'h00;
      pout_r <= 1'b0;
      byp_r <= 1'b0;
      pin_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      pout_r <= pout_nxt;
      byp_r <= byp_nxt;
      pin_r <= pin_nxt;
    end
  end

  assign RDATA = rdata_r;
  assign PRESC_OUT = pout_r;
  assign B_BYPASS = byp_r;
  assign STATUS_PIN = pin_r;

  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence s_stat_wr;
    WR_EN && addr_full == PSM_OFF_STAT;
  endsequence

  property p_sel_locked;
    s_stat_wr ##0 lock_r[PSM_LOCK_BIT] |=> $stable(stat_r);
  endproperty
  a_sel_locked: assert property (p_sel_locked) else $error("Selector changed while locked");

  property p_sel_taken;
    s_stat_wr ##0 !lock_r[PSM_LOCK_BIT] |=> stat_r == $past(WDATA);
  endproperty
  a_sel_taken: assert property (p_sel_taken) else $error("Selector write lost");

  property p_gnd;
    sel == PSM_S_GND |=> !STATUS_PIN;
  endproperty
  a_gnd: assert property (p_gnd) else $error("Ground code not low");

  property p_ndiv;
    sel == PSM_S_NDIV |=> STATUS_PIN == $past(SRC.n_div_dly);
  endproperty
  a_ndiv: assert property (p_ndiv) else $error("N divider not routed");

  property p_pfd_dn;
    sel == PSM_S_DN |=> STATUS_PIN == $past(SRC.pfd_dn);
  endproperty
  a_pfd_dn: assert property (p_pfd_dn) else $error("PFD down not routed");

  property p_unassigned;
    !sel[5] && sel > PSM_S_DN |=> !STATUS_PIN;
  endproperty
  a_unassigned: assert property (p_unassigned) else $error("Unassigned code not low");

  property p_second_reference_input_diff;
    sel == PSM_S_SECOND_REFERENCE_INPUT && SRC.diff_mode |=> !STATUS_PIN;
  endproperty
  a_second_reference_input_diff: assert property (p_second_reference_input_diff) else $error("Second reference shown in differential");

  property p_first_reference_input;
    sel == PSM_S_FIRST_REFERENCE_INPUT |=> STATUS_PIN == $past(SRC.first_reference_input);
  endproperty
  a_first_reference_input: assert property (p_first_reference_input) else $error("First reference not routed");

  // Divide by one only once the old countdown has drained to zero
  sequence s_div1;
    (pcode == PSM_P_FD1 && cnt_r == 6'h00) [*2];
  endsequence

  property p_div1;
    s_div1 |=> PRESC_OUT;
  endproperty
  a_div1: assert property (p_div1) else $error("Divide by one not continuous");

  property p_dm8;
    pcode == PSM_P_DM8 && SWALLOW_ZERO |-> ratio == 6'h08;
  endproperty
  a_dm8: assert property (p_dm8) else $error("Code 100 ratio wrong");

  property p_dm16;
    pcode == PSM_P_DM16 && MOD_HI && !SWALLOW_ZERO |-> ratio == 6'h11;
  endproperty
  a_dm16: assert property (p_dm16) else $error("Code 101 high ratio wrong");

  property p_dm32;
    pcode == PSM_P_DM32 && SWALLOW_ZERO && cnt_r == 6'h00 |=> cnt_r == 6'h1f;
  endproperty
  a_dm32: assert property (p_dm32) else $error("Code 110 reload wrong");

  property p_dm23;
    pcode == PSM_P_DM23 && SWALLOW_ZERO |-> ratio == 6'h02;
  endproperty
  a_dm23: assert property (p_dm23) else $error("Code 010 zero ratio wrong");

  property p_bypass;
    ##1 B_BYPASS |-> $past(presc_r[PSM_BYP_BIT]) && $past(fixed_mode);
  endproperty
  a_bypass: assert property (p_bypass) else $error("Bypass outside fixed divide");
endmodule : psm_top
`default_nettype wire

//--- rtl/psm_pkg.sv
// Constants, register map and source bundle for the prescaler and status pin mux.
// Assumes a byte-wide serial control port decodes addresses and strobes the writes.
package psm_pkg;
  // Register offsets
  localparam logic [9:0] PSM_OFF_PRESC = 10'h016; // Prescaler control
  localparam logic [9:0] PSM_OFF_STAT = 10'h017; // Status pin select
  localparam logic [9:0] PSM_OFF_LOCK = 10'h01d; // Holds selector lock bit
  // Field positions
  localparam int PSM_PRESC_LSB = 0; // Prescaler code [2:0]
  localparam int PSM_BYP_BIT = 3; // B counter bypass
  localparam int PSM_SEL_LSB = 2; // Selector [7:2]
  localparam int PSM_LOCK_BIT = 7; // Lock bit in 0x01D
  // Reset values
  localparam logic [7:0] PSM_RST_PRESC = 8'h06; // Code 110
  localparam logic [7:0] PSM_RST_STAT = 8'h00; // Ground
  localparam logic [7:0] PSM_RST_LOCK = 8'h00;
  // Prescaler codes
  localparam logic [2:0] PSM_P_FD1 = 3'h0;
  localparam logic [2:0] PSM_P_FD2 = 3'h1;
  localparam logic [2:0] PSM_P_DM23 = 3'h2;
  localparam logic [2:0] PSM_P_DM45 = 3'h3;
  localparam logic [2:0] PSM_P_DM8 = 3'h4;
  localparam logic [2:0] PSM_P_DM16 = 3'h5;
  localparam logic [2:0] PSM_P_DM32 = 3'h6;
  localparam logic [2:0] PSM_P_FD3 = 3'h7;
  // Selector codes
  localparam logic [5:0] PSM_S_GND = 6'h00;
  localparam logic [5:0] PSM_S_NDIV = 6'h01;
  localparam logic [5:0] PSM_S_RDIV = 6'h02;
  localparam logic [5:0] PSM_S_SWAL = 6'h03;
  localparam logic [5:0] PSM_S_PRESC = 6'h04;
  localparam logic [5:0] PSM_S_UP = 6'h05;
  localparam logic [5:0] PSM_S_DN = 6'h06;
  localparam logic [5:0] PSM_S_GND2 = 6'h20;
  localparam logic [5:0] PSM_S_FIRST_REFERENCE_INPUT = 6'h21;
  localparam logic [5:0] PSM_S_SECOND_REFERENCE_INPUT = 6'h22;
  localparam logic [5:0] PSM_S_RSEL = 6'h23;
  localparam logic [5:0] PSM_S_RUNS = 6'h24;
  // Internal signals the pin may show, plus the two reference select controls
  typedef struct packed {
    logic n_div_dly; // N divider after delay
    logic r_div_dly; // R divider after delay
    logic swallow; // Swallow counter output
    logic pfd_up; // PFD up pulse
    logic pfd_dn; // PFD down pulse
    logic first_reference_input; // First reference input
    logic second_reference_input; // Second reference input
    logic ref_sel2; // High when PLL uses second reference
    logic diff_mode; // Differential reference active
  } psm_src_t;
endpackage : psm_pkg

//--- test/tb.sv
// Self-checking bench for the prescaler and status pin mux.
// Assumes psm_top at default address width; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import psm_pkg::*;
  logic MCLK, RST, WR_EN, RD_EN, SWALLOW_ZERO, MOD_HI; // Bench controls
  logic [9:0] ADDR; // Register address
  logic [7:0] WDATA, RDATA; // Register data
  psm_src_t SRC; // Internal sources
  logic PRESC_OUT, B_BYPASS, STATUS_PIN; // Observed outputs
  int n_mismatch = 0; // Mismatches
  int checks_done = 0; // Comparisons
  psm_top DUT (.MCLK(MCLK), .RST(RST), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA),
    .RDATA(RDATA), .SWALLOW_ZERO(SWALLOW_ZERO), .MOD_HI(MOD_HI), .SRC(SRC), .PRESC_OUT(PRESC_OUT),
    .B_BYPASS(B_BYPASS), .STATUS_PIN(STATUS_PIN));
  // Free-running clock, 4 ns period
  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end
  // Verdict and end of run
  task automatic tally_and_finish();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  // Compare seen against expected
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One register write
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge MCLK);
    WR_EN = 1'b1;
    ADDR = a;
    WDATA = d;
    @(negedge MCLK);
    WR_EN = 1'b0;
  endtask : wr
  // Read and compare one register
  task automatic rc(input logic [9:0] a, input logic [7:0] exp);
    @(negedge MCLK);
    RD_EN = 1'b1;
    ADDR = a;
    @(negedge MCLK);
    RD_EN = 1'b0;
    check("register", RDATA, exp);
  endtask : rc
  // Cycles from one prescaler pulse to the next
  task automatic period(output logic [7:0] n);
    int k;
    n = 8'h00;
    k = 0;
    while (PRESC_OUT !== 1'b1 && k < 100) begin
      @(negedge MCLK);
      k++;
    end
    do begin
      @(negedge MCLK);
      n++;
    end while (PRESC_OUT !== 1'b1 && n < 8'h64);
  endtask : period
  // Reset values, unmapped place and selector lock
  task automatic test_regs();
    rc(PSM_OFF_PRESC, 8'h06);
    rc(PSM_OFF_STAT, 8'h00);
    rc(PSM_OFF_LOCK, 8'h00);
    wr(10'h3ff, 8'h5a);
    rc(10'h3ff, 8'h00);
    wr(PSM_OFF_STAT, 8'h08);
    wr(PSM_OFF_LOCK, 8'h80);
    rc(PSM_OFF_LOCK, 8'h80);
    wr(PSM_OFF_STAT, 8'h04);
    rc(PSM_OFF_STAT, 8'h08);
    wr(PSM_OFF_LOCK, 8'h00);
    wr(PSM_OFF_STAT, 8'h04);
    rc(PSM_OFF_STAT, 8'h04);
  endtask : test_regs
  // Every prescaler code, dual-modulus codes with swallow zero and nonzero
  task automatic test_presc();
    logic [7:0] n;
    logic [2:0] cd [13] = '{0, 1, 7, 2, 2, 3, 3, 4, 4, 5, 5, 6, 6};
    bit zr [13] = '{0, 0, 0, 0, 1, 0, 1, 1, 0, 0, 1, 0, 1};
    bit mh [13] = '{1, 1, 1, 1, 0, 1, 0, 1, 1, 1, 0, 1, 0};
    logic [7:0] rat [13] = '{1, 2, 3, 3, 2, 5, 4, 8, 5, 17, 16, 33, 32};
    period(n);
    period(n);
    check("reset ratio", n, 8'h20);
    for (int i = 0; i < 13; i++) begin
      wr(PSM_OFF_PRESC, {5'h00, cd[i]});
      SWALLOW_ZERO = zr[i];
      MOD_HI = mh[i];
      period(n);
      period(n);
      check("ratio", n, rat[i]);
    end
  endtask : test_presc
  // Bypass only counts in fixed divide
  task automatic test_bypass();
    logic [7:0] v [3] = '{8'h08, 8'h0a, 8'h0f};
    logic e [3] = '{1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 3; i++) begin
      wr(PSM_OFF_PRESC, v[i]);
      repeat (2) @(negedge MCLK);
      check("bypass", {7'h00, B_BYPASS}, {7'h00, e[i]});
    end
  endtask : test_bypass
  // Expected pin level for a selector and source set
  function automatic logic pick(input logic [5:0] c, input psm_src_t s);
    case (c)
      6'h01: return s.n_div_dly;
      6'h02: return s.r_div_dly;
      6'h03: return s.swallow;
      6'h04: return 1'b1; // Prescaler held at ratio 1
      6'h05: return s.pfd_up;
      6'h06: return s.pfd_dn;
      6'h21: return s.first_reference_input;
      6'h22: return s.second_reference_input & ~s.diff_mode;
      6'h23: return (s.ref_sel2 & ~s.diff_mode) ? s.second_reference_input : s.first_reference_input;
      6'h24: return s.diff_mode ? 1'b0 : (s.ref_sel2 ? s.first_reference_input : s.second_reference_input);
      default: return 1'b0;
    endcase
  endfunction : pick
  // Each selector against walking and mixed sources
  task automatic test_mux();
    logic [5:0] cs [14] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h1f, 6'h20,
      6'h21, 6'h22, 6'h23, 6'h24};
    logic [8:0] ps [15] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h008, 9'h004, 9'h002, 9'h001,
      9'h000, 9'h005, 9'h009, 9'h00a, 9'h007, 9'h00b};
    wr(PSM_OFF_PRESC, 8'h00);
    for (int i = 0; i < 14; i++) begin
      wr(PSM_OFF_STAT, {cs[i], 2'b00});
      for (int j = 0; j < 15; j++) begin
        SRC = psm_src_t'(ps[j]);
        repeat (2) @(negedge MCLK);
        check("status pin", {7'h00, STATUS_PIN}, {7'h00, pick(cs[i], SRC)});
      end
    end
  endtask : test_mux
  // Main sequence
  initial begin
    RST = 1'b1;
    WR_EN = 1'b0;
    RD_EN = 1'b0;
    ADDR = 10'h000;
    WDATA = 8'h00;
    SWALLOW_ZERO = 1'b1;
    MOD_HI = 1'b0;
    SRC = psm_src_t'(9'h000);
    repeat (2) @(negedge MCLK);
    RST = 1'b0;
    test_regs();
    test_presc();
    test_bypass();
    test_mux();
    tally_and_finish();
  end
  // Watchdog against a hang
  initial begin
    #80000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
